// ===== hdl/cbk_params.svh
// constants for the clock bank output control block
// assumes byte addressing on a 32-bit axi4-lite bus
`ifndef CBK_PARAMS_SVH
`define CBK_PARAMS_SVH
// register byte offsets
`define CBK_CTRL_OFS 4'h0
`define CBK_PHASE_OFS 4'h4
`define CBK_WDOG_OFS 4'h8
`define CBK_STATUS_OFS 4'hc
// control register fields
`define CBK_CTRL_DIS_LSB 0
`define CBK_CTRL_DIS_MSB 4
`define CBK_CTRL_MODE_LSB 5
`define CBK_CTRL_MODE_MSB 6
`define CBK_CTRL_INV_LSB 7
`define CBK_CTRL_INV_MSB 8
// reset values
`define CBK_CTRL_RST 9'h000
`define CBK_PHASE_RST 8'h04
`define CBK_WDOG_RST 16'h0100
// bank indices
`define CBK_BANK3_IDX 2
`define CBK_BANK4_IDX 3
`define CBK_LOOP_IDX 4
// lock detector and test reset counts
`define CBK_LOCK_ERR_CNT 3'h4
`define CBK_LOCK_GOOD_CNT 6'h20
`define CBK_TEST_RST_EDGES 3'h5
// axi responses
`define CBK_RESP_OKAY 2'b00
`define CBK_RESP_SLVERR 2'b10
`endif

// ===== hdl/cbk_pkg.sv
// types shared by the clock bank output control block
// assumes nothing of its surroundings
package cbk_pkg;
  // two-bit code of a three-level strap
  typedef enum logic [1:0] {
    CBK_LOW = 2'b00,
    CBK_MID = 2'b01,
    CBK_HIGH = 2'b10
  } cbk_tri_t;
  // per-bank disable control
  typedef struct packed {
    logic dis;        // bank disable
    logic hiz_sel;    // disabled state is high impedance
    logic test;       // factory test, disables ignored
    logic force_hiz;  // test reset floats the bank
  } cbk_bank_cfg_t;
endpackage

// ===== hdl/cbk_bank.sv
// one output bank: glitch-free park, high impedance, inversion
// assumes src_in is the bank clock from the matrix, sampled on aclk
`timescale 1ns/10ps
`default_nettype none
module cbk_bank #(
  parameter int NOUT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_in,
  input wire cbk_pkg::cbk_bank_cfg_t cfg,
  input wire logic [NOUT-1:0] inv_mask,
  output logic [NOUT-1:0] q_out,
  output logic oe_out,
  output logic parked_out
);
  logic park_r;    // bank held in parked state
  logic park_nxt;  // next park state
  logic park_req;  // disable asks for park

  // park only outside test mode and with park selected
  assign park_req = cfg.dis & ~cfg.hiz_sel & ~cfg.test;

  // park and release only while the source is low, so no short pulse
  always_comb begin
    park_nxt = park_r;
    if (!src_in) begin
      park_nxt = park_req;
    end
  end

  // park state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      park_r <= 1'b0;
    end else begin
      park_r <= park_nxt;
    end
  end

  // outputs: gated clock, inverted per mask; parked inverted outputs sit high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_out <= '0;
    end else begin
      q_out <= {NOUT{src_in & ~park_nxt}} ^ inv_mask;
    end
  end

  // high impedance acts at once, without a clock edge
  assign oe_out = ~((cfg.dis & cfg.hiz_sel & ~cfg.test) | cfg.force_hiz);
  assign parked_out = park_r;
endmodule // cbk_bank
`default_nettype wire

// ===== hdl/cbk_ctrl.sv
// clock bank output control: disables, bank three inversion,
// lock detector with watchdog, factory test reset, axi4-lite registers
// assumes ref and loopback clocks are slow levels synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
`include "cbk_params.svh"
module cbk_ctrl #(
  parameter int WD_WIDTH = 16,
  parameter int PH_WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clocks as levels
  input wire logic ref_clock_input,
  input wire logic loopback_clock_input,
  input wire logic [4:0] bank_clk_in,
  // bank outputs and enables
  output logic [3:0] bank1_q,
  output logic [3:0] bank2_q,
  output logic bank3_pair_a_out0,
  output logic bank3_pair_b_out0,
  output logic bank3_pair_a_out1,
  output logic bank3_pair_b_out1,
  output logic [3:0] bank4_q,
  output logic [1:0] loopback_q,
  output logic [4:0] bank_oe,
  // pll and matrix control
  output logic lock_out,
  output logic pll_bypass_out,
  output logic sm_hold_out,
  output logic sm_load_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [8:0] ctrl_r;            // disables, output mode, invert select
  logic [PH_WIDTH-1:0] phase_r;  // phase error limit in aclk cycles
  logic [WD_WIDTH-1:0] wdog_r;   // watchdog time-out in reference edges
  logic [4:0] bank_disable_in;   // per-bank disable, bit 4 loopback bank
  logic loopback_bank_disable_in;
  logic bank4_disable_in;
  cbk_pkg::cbk_tri_t mode_sel;   // disabled-state select
  cbk_pkg::cbk_tri_t bank3_invert_select;

  assign bank_disable_in = ctrl_r[`CBK_CTRL_DIS_MSB:`CBK_CTRL_DIS_LSB];
  assign loopback_bank_disable_in = bank_disable_in[`CBK_LOOP_IDX];
  assign bank4_disable_in = bank_disable_in[`CBK_BANK4_IDX];

  // code 2'b11 is illegal; it falls to mid, the safe state
  always_comb begin
    unique case (ctrl_r[`CBK_CTRL_MODE_MSB:`CBK_CTRL_MODE_LSB])
      2'b00: mode_sel = cbk_pkg::CBK_LOW;
      2'b10: mode_sel = cbk_pkg::CBK_HIGH;
      default: mode_sel = cbk_pkg::CBK_MID;
    endcase
  end

  always_comb begin
    unique case (ctrl_r[`CBK_CTRL_INV_MSB:`CBK_CTRL_INV_LSB])
      2'b00: bank3_invert_select = cbk_pkg::CBK_LOW;
      2'b10: bank3_invert_select = cbk_pkg::CBK_HIGH;
      default: bank3_invert_select = cbk_pkg::CBK_MID;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  logic test_mode;   // factory test
  logic test_rst;    // test reset in progress
  assign test_mode = (mode_sel == cbk_pkg::CBK_MID);
  assign test_rst = test_mode & bank4_disable_in;
  // pll replaced by the reference level; matrix keeps dividing and skewing
  assign pll_bypass_out = test_mode;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on sampled clocks
  logic ref_prev_r;
  logic fb_prev_r;
  logic ref_rise;
  logic fb_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_r <= 1'b0;
      fb_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_clock_input;
      fb_prev_r <= loopback_clock_input;
    end
  end
  assign ref_rise = ref_clock_input & ~ref_prev_r;
  assign fb_rise = loopback_clock_input & ~fb_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // factory test reset: count five reference rises, then load and hold
  logic [2:0] trst_cnt_r;  // reference rises seen
  logic sm_hold_r;         // state machines loaded and held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trst_cnt_r <= '0;
    end else if (!test_rst) begin
      trst_cnt_r <= '0;
    end else if (ref_rise && trst_cnt_r != `CBK_TEST_RST_EDGES) begin
      trst_cnt_r <= trst_cnt_r + 3'h1;
    end
  end

  // load pulse on the fifth rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sm_load_out <= 1'b0;
    end else begin
      sm_load_out <= test_rst & ref_rise &
                     (trst_cnt_r == `CBK_TEST_RST_EDGES - 3'h1);
    end
  end

  // hold stays until bank four disable drops or test mode ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sm_hold_r <= 1'b0;
    end else if (!test_rst) begin
      sm_hold_r <= 1'b0;
    end else if (ref_rise && trst_cnt_r == `CBK_TEST_RST_EDGES - 3'h1) begin
      sm_hold_r <= 1'b1;
    end
  end
  assign sm_hold_out = sm_hold_r;

  ////////////////////////////////////////////////////////////////////////////
  // output banks
  logic [3:0] bank3_invert_select_mask;       // bank three inversion per output
  logic [3:0] q_all [0:4];     // outputs of every bank
  logic [4:0] parked;
  always_comb begin
    unique case (bank3_invert_select)
      cbk_pkg::CBK_LOW: bank3_invert_select_mask = 4'ha;
      cbk_pkg::CBK_HIGH: bank3_invert_select_mask = 4'hf;
      cbk_pkg::CBK_MID: bank3_invert_select_mask = 4'h0;
    endcase
  end

  // one controller per bank; the loopback bank has two outputs
  for (genvar g = 0; g < 5; g++) begin : g_bank
    localparam int N = (g == `CBK_LOOP_IDX) ? 2 : 4;
    cbk_pkg::cbk_bank_cfg_t cfg;
    logic [N-1:0] q;
    assign cfg = '{dis: bank_disable_in[g], hiz_sel: (mode_sel == cbk_pkg::CBK_HIGH),
                   test: test_mode, force_hiz: test_rst};
    cbk_bank #(.NOUT(N)) u_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .src_in(bank_clk_in[g]),
      .cfg(cfg),
      .inv_mask((g == `CBK_BANK3_IDX) ? bank3_invert_select_mask[N-1:0] : {N{1'b0}}),
      .q_out(q),
      .oe_out(bank_oe[g]),
      .parked_out(parked[g])
    );
    if (N == 2) begin : g_pad
      assign q_all[g] = {2'b00, q};
    end else begin : g_full
      assign q_all[g] = q;
    end
  end

  assign bank1_q = q_all[0];
  assign bank2_q = q_all[1];
  // bit order a0, a1, b0, b1
  assign bank3_pair_a_out0 = q_all[`CBK_BANK3_IDX][0];
  assign bank3_pair_a_out1 = q_all[`CBK_BANK3_IDX][1];
  assign bank3_pair_b_out0 = q_all[`CBK_BANK3_IDX][2];
  assign bank3_pair_b_out1 = q_all[`CBK_BANK3_IDX][3];
  assign bank4_q = q_all[3];
  assign loopback_q = q_all[4][1:0];

  ////////////////////////////////////////////////////////////////////////////
  // lock detector: phase distance from last reference rise
  logic [PH_WIDTH-1:0] ph_cnt_r;  // aclk cycles since reference rise
  logic phase_err;                // this loopback cycle is erroneous
  logic [2:0] err_cnt_r;          // consecutive error cycles
  logic [5:0] good_cnt_r;         // consecutive clean cycles
  logic [WD_WIDTH-1:0] wd_cnt_r;  // reference rises since loopback rise
  logic lock_r;

  // saturating counter, so a very late edge still reads as error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_cnt_r <= '0;
    end else if (ref_rise) begin
      ph_cnt_r <= '0;
    end else if (ph_cnt_r != {PH_WIDTH{1'b1}}) begin
      ph_cnt_r <= ph_cnt_r + PH_WIDTH'(1);
    end
  end
  assign phase_err = (ph_cnt_r > phase_r);

  // consecutive error and clean cycle counters, per loopback rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_cnt_r <= '0;
      good_cnt_r <= '0;
    end else if (fb_rise) begin
      if (phase_err) begin
        good_cnt_r <= '0;
        if (err_cnt_r != `CBK_LOCK_ERR_CNT) begin
          err_cnt_r <= err_cnt_r + 3'h1;
        end
      end else begin
        err_cnt_r <= '0;
        if (good_cnt_r != `CBK_LOCK_GOOD_CNT) begin
          good_cnt_r <= good_cnt_r + 6'h01;
        end
      end
    end
  end

  // watchdog counts reference rises; reliable only with reference running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt_r <= '0;
    end else if (fb_rise) begin
      wd_cnt_r <= '0;
    end else if (ref_rise && wd_cnt_r != wdog_r) begin
      wd_cnt_r <= wd_cnt_r + WD_WIDTH'(1);
    end
  end

  // lock flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_r <= 1'b0;
    end else if (lock_r) begin
      if (fb_rise && phase_err && err_cnt_r == `CBK_LOCK_ERR_CNT - 3'h1) begin
        lock_r <= 1'b0;
      end else if (wd_cnt_r == wdog_r) begin
        lock_r <= 1'b0;
      end
    end else if (fb_rise && !phase_err &&
                 good_cnt_r == `CBK_LOCK_GOOD_CNT - 6'h01) begin
      lock_r <= 1'b1;
    end
  end
  assign lock_out = lock_r;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data taken in either order
  logic aw_got_r;
  logic w_got_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  assign wr_go = aw_got_r & w_got_r;

  // hold channels until both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (wr_go) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // register writes by byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CBK_CTRL_RST;
      phase_r <= PH_WIDTH'(`CBK_PHASE_RST);
      wdog_r <= WD_WIDTH'(`CBK_WDOG_RST);
    end else if (wr_go) begin
      unique case (aw_addr_r)
        `CBK_CTRL_OFS: begin
          if (w_strb_r[0]) ctrl_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) ctrl_r[8] <= w_data_r[8];
        end
        `CBK_PHASE_OFS: begin
          if (w_strb_r[0]) phase_r <= w_data_r[PH_WIDTH-1:0];
        end
        `CBK_WDOG_OFS: begin
          if (w_strb_r[0]) wdog_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) wdog_r[WD_WIDTH-1:8] <= w_data_r[WD_WIDTH-1:8];
        end
        default: begin
        end
      endcase
    end
  end

  // write response one cycle after both channels taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CBK_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r == `CBK_CTRL_OFS || aw_addr_r == `CBK_PHASE_OFS ||
                      aw_addr_r == `CBK_WDOG_OFS) ? `CBK_RESP_OKAY : `CBK_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read; status shows lock, test state and bank states
  logic [31:0] rd_mux;
  logic rd_ok;
  assign s_axi_arready = ~s_axi_rvalid;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `CBK_CTRL_OFS: rd_mux = {23'h000000, ctrl_r};
      `CBK_PHASE_OFS: rd_mux = {{(32-PH_WIDTH){1'b0}}, phase_r};
      `CBK_WDOG_OFS: rd_mux = {{(32-WD_WIDTH){1'b0}}, wdog_r};
      `CBK_STATUS_OFS: rd_mux = {19'h00000, ~bank_oe, parked, sm_hold_r,
                                 test_mode, lock_r};
      default: rd_ok = 1'b0;
    endcase
  end

  // read data registered, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CBK_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `CBK_RESP_OKAY : `CBK_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // cbk_ctrl
`default_nettype wire

// ===== testbench/cbk_clk_partner.sv
// board-side model: reference, loopback and bank clocks as levels on aclk
// assumes the bench sets delay, stop and test hold as static straps
`timescale 1ns/10ps
`default_nettype none
module cbk_clk_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] fb_dly,
  input wire logic fb_stop,
  input wire logic test_hold,
  output logic ref_clock_input,
  output logic loopback_clock_input,
  output logic [4:0] bank_clk_in
);
  logic [3:0] cnt_r; // phase within a 16-cycle reference period
  logic [3:0] fb_ph; // loopback phase, lagging by fb_dly cycles
  ////////////////////////////////////////////////////////////////
  // period counter, only this drives every clock level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign fb_ph = cnt_r - fb_dly;
  // reference never stops, lock reporting relies on it
  assign ref_clock_input = !cnt_r[3];
  // loopback parked low while in test or when removed
  assign loopback_clock_input = !fb_ph[3] && !fb_stop && !test_hold;
  // bank clocks of four aclk cycles, so six cycles fit in 24
  assign bank_clk_in = {5{cnt_r[1]}};
endmodule // cbk_clk_partner
`default_nettype wire

// ===== testbench/cbk_ctrl_properties.sv
// assertions on the clock bank control ports
// assumes aw and w are offered together with full strobes
`timescale 1ns/10ps
`default_nettype none
module cbk_ctrl_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic ref_clock_input,
  input wire logic loopback_clock_input,
  input wire logic [4:0] bank_clk_in,
  input wire logic [3:0] bank1_q,
  input wire logic bank3_pair_a_out0,
  input wire logic bank3_pair_b_out0,
  input wire logic bank3_pair_a_out1,
  input wire logic bank3_pair_b_out1,
  input wire logic [4:0] bank_oe,
  input wire logic lock_out,
  input wire logic pll_bypass_out,
  input wire logic sm_hold_out,
  input wire logic sm_load_out
);
  logic go_r; // control write taken last edge
  logic [8:0] pend_r; // write data in flight
  logic [8:0] ctrl_r; // shadow of the control register
  logic [4:0] st_r; // cycles since control last written
  logic ref_d, fb_d; // previous clock levels
  logic [5:0] fbu_r; // loopback rises while unlocked
  logic [2:0] fbl_r; // loopback rises while locked
  logic [2:0] wd_r; // reference rises without loopback rise
  logic [2:0] rc_r; // reference rises during test reset
  wire logic ref_up = ref_clock_input & ~ref_d;
  wire logic fb_up = loopback_clock_input & ~fb_d;
  wire logic [1:0] md = ctrl_r[6:5];
  wire logic [1:0] iv = ctrl_r[8:7];
  ////////////////////////////////////////////////////////////////
  // shadow control, same timing as the design register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_r <= 1'b0;
      pend_r <= 9'h000;
      ctrl_r <= 9'h000;
    end else begin
      go_r <= s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & (s_axi_awaddr == 4'h0);
      pend_r <= s_axi_wdata[8:0];
      if (go_r) ctrl_r <= pend_r;
    end
  end
  // settle counter, saturates so long runs do not wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || go_r) st_r <= 5'h00;
    else if (st_r != 5'h1f) st_r <= st_r + 5'h01;
  end
  // edge counters for lock and test reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_d <= 1'b0;
      fb_d <= 1'b0;
      fbu_r <= 6'h00;
      fbl_r <= 3'h0;
      wd_r <= 3'h0;
      rc_r <= 3'h0;
    end else begin
      ref_d <= ref_clock_input;
      fb_d <= loopback_clock_input;
      if (lock_out) fbu_r <= 6'h00;
      else if (fb_up && fbu_r != 6'h3f) fbu_r <= fbu_r + 6'h01;
      if (!lock_out) fbl_r <= 3'h0;
      else if (fb_up && fbl_r != 3'h7) fbl_r <= fbl_r + 3'h1;
      if (fb_up) wd_r <= 3'h0;
      else if (ref_up && wd_r != 3'h7) wd_r <= wd_r + 3'h1;
      if (!(md[0] && ctrl_r[3]) || sm_hold_out) rc_r <= 3'h0;
      else if (ref_up && rc_r != 3'h7) rc_r <= rc_r + 3'h1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_load_then_hold;
    sm_load_out ##1 (sm_hold_out && !sm_load_out)[*3];
  endsequence
  property p_enabled; md == 2'b00 |-> bank_oe == 5'h1f; endproperty
  property p_hiz; md == 2'b10 |-> bank_oe == ~ctrl_r[4:0]; endproperty
  property p_test; md[0] |-> bank_oe == (ctrl_r[3] ? 5'h00 : 5'h1f); endproperty
  property p_bypass; pll_bypass_out == md[0]; endproperty
  property p_park;
    (st_r >= 5'h1a && md == 2'b00 && ctrl_r[0] && ctrl_r[2]) |->
      bank1_q == 4'h0 && bank3_pair_a_out0 == (iv == 2'b10) && bank3_pair_a_out1 == !iv[0];
  endproperty
  property p_inv;
    (st_r >= 5'h08 && !md[0] && !ctrl_r[2]) |->
      bank3_pair_a_out0 == ($past(bank_clk_in[2]) ^ (iv == 2'b10)) && bank3_pair_a_out1 == ($past(bank_clk_in[2]) ^ !iv[0])
      && bank3_pair_b_out0 == bank3_pair_a_out0 && bank3_pair_b_out1 == bank3_pair_a_out1;
  endproperty
  property p_lock_rise; $rose(lock_out) |-> fbu_r >= 6'h20; endproperty
  property p_lock_drop; $fell(lock_out) |-> (fbl_r >= 3'h4 || wd_r != 3'h0); endproperty
  property p_load_count; sm_load_out |-> rc_r == 3'h5; endproperty
  property p_load_hold; sm_load_out |-> s_load_then_hold; endproperty
  a_enabled: assert property (p_enabled) else $error("bank float without select");
  a_hiz: assert property (p_hiz) else $error("enables differ from disables");
  a_test: assert property (p_test) else $error("test enables wrong");
  a_bypass: assert property (p_bypass) else $error("bypass differs from mode");
  a_park: assert property (p_park) else $error("parked levels wrong");
  a_inv: assert property (p_inv) else $error("bank three inversion wrong");
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose early");
  a_lock_drop: assert property (p_lock_drop) else $error("lock dropped early");
  a_load_count: assert property (p_load_count) else $error("load not after five rises");
  a_load_hold: assert property (p_load_hold) else $error("no hold after load");
endmodule // cbk_ctrl_properties
bind cbk_ctrl cbk_ctrl_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .ref_clock_input(ref_clock_input),
  .loopback_clock_input(loopback_clock_input), .bank_clk_in(bank_clk_in), .bank1_q(bank1_q),
  .bank3_pair_a_out0(bank3_pair_a_out0), .bank3_pair_b_out0(bank3_pair_b_out0),
  .bank3_pair_a_out1(bank3_pair_a_out1), .bank3_pair_b_out1(bank3_pair_b_out1), .bank_oe(bank_oe),
  .lock_out(lock_out), .pll_bypass_out(pll_bypass_out), .sm_hold_out(sm_hold_out), .sm_load_out(sm_load_out));
`default_nettype wire

// ===== testbench/cbk_ctrl_tb_top.sv
// self-checking bench: registers, disables, inversion, lock, test reset
// assumes the partner model supplies every clock level
`timescale 1ns/10ps
`default_nettype none
module cbk_ctrl_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb, b1, b2, b4, fb_dly;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, lpq;
  logic refc, fbc, fb_stop, test_hold, lock, byp, hold, load, a0, b0, a1, b1x, rp;
  logic [4:0] bclk, oe;
  logic [8:0] ctrl; // control word under test
  int err_count, compares, seed, i, n;
  // clock, 20 ns period
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  cbk_clk_partner u_part (.aclk(aclk), .aresetn(aresetn), .fb_dly(fb_dly), .fb_stop(fb_stop),
    .test_hold(test_hold), .ref_clock_input(refc), .loopback_clock_input(fbc), .bank_clk_in(bclk));
  cbk_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_clock_input(refc),
    .loopback_clock_input(fbc), .bank_clk_in(bclk), .bank1_q(b1), .bank2_q(b2), .bank3_pair_a_out0(a0),
    .bank3_pair_b_out0(b0), .bank3_pair_a_out1(a1), .bank3_pair_b_out1(b1x), .bank4_q(b4), .loopback_q(lpq),
    .bank_oe(oe), .lock_out(lock), .pll_bypass_out(byp), .sm_hold_out(hold), .sm_load_out(load));
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a wait that ran out ends the run
  task automatic tmo;
    err_count++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask
  // one bus transfer; read data compared under mask m
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] er);
    int k;
    logic aw_hit, w_hit, ar_hit, done;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    done = 1'b0;
    for (k = 0; k < 50 && !done; k++) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      ar_hit = arvalid && arready;
      if (wr ? bvalid : rvalid) begin
        chk(wr ? bresp : rresp, er);
        if (!wr) chk(rdata & m, d & m);
        done = 1'b1;
      end
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (ar_hit) arvalid <= 1'b0;
      if (done) {bready, rready} <= 2'b00;
    end
    if (!done) tmo();
  endtask
  // lock keeps its level at least lo cycles, reaches v within hi
  task automatic lock_wait(input logic v, input int lo, input int hi);
    int k;
    for (k = 0; k < hi && lock !== v; k++) @(negedge aclk);
    if (lock !== v) tmo();
    chk(k >= lo, 1'b1);
  endtask
  // expected enables from a control word
  function automatic logic [4:0] exp_oe(input logic [8:0] c);
    if (c[5]) exp_oe = c[3] ? 5'h00 : 5'h1f;
    else if (c[6]) exp_oe = ~c[4:0];
    else exp_oe = 5'h1f;
  endfunction
  // expected status float and park fields
  function automatic logic [9:0] exp_st(input logic [8:0] c);
    exp_st = {~exp_oe(c), (c[6:5] == 2'b00) ? c[4:0] : 5'h00};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 61;
    err_count = 0;
    compares = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, fb_stop, test_hold} = 7'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    fb_dly = 4'h1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place, short watchdog
    bus(1'b0, 4'h0, 32'h0, 32'h1ff, 2'b00);
    bus(1'b0, 4'h4, 32'h4, 32'hff, 2'b00);
    bus(1'b0, 4'h8, 32'h100, 32'hffff, 2'b00);
    bus(1'b0, 4'hc, 32'h0, 32'h7, 2'b00);
    bus(1'b1, 4'h2, 32'h1f, 32'h0, 2'b10);
    bus(1'b0, 4'h2, 32'h0, 32'hffffffff, 2'b10);
    bus(1'b1, 4'h8, 32'h8, 32'h0, 2'b00);
    // lock, then phase error, relock, loopback removed
    lock_wait(1'b1, 440, 700);
    bus(1'b0, 4'hc, 32'h1, 32'h1, 2'b00);
    fb_dly <= 4'ha;
    lock_wait(1'b0, 40, 120);
    fb_dly <= 4'h1;
    lock_wait(1'b1, 440, 700);
    fb_stop <= 1'b1;
    lock_wait(1'b0, 100, 250);
    fb_stop <= 1'b0;
    // random controls with two corners, never passing through test
    for (i = 0; i < 12; i++) begin
      ctrl = 9'($random(seed));
      ctrl[5] = 1'b0;
      if (i == 0) ctrl = 9'h185;
      if (i == 1) ctrl = 9'h05f;
      bus(1'b1, 4'h0, {23'h0, ctrl}, 32'h0, 2'b00);
      chk(oe, exp_oe(ctrl));
      repeat (30) @(posedge aclk);
      if (!ctrl[6]) chk({b1 & {4{ctrl[0]}}, b2 & {4{ctrl[1]}}, b4 & {4{ctrl[3]}}, lpq & {2{ctrl[4]}}}, 32'h0);
      chk({a0 ^ a1, a0 ^ b0, a1 ^ b1x}, {ctrl[8:7] == 2'b00, 2'b00});
      bus(1'b0, 4'hc, {19'h0, exp_st(ctrl), 3'h0}, 32'h1ff8, 2'b00);
    end
    // factory test: disables ignored, then test reset
    test_hold <= 1'b1;
    bus(1'b1, 4'h0, 32'h037, 32'h0, 2'b00);
    chk({byp, oe}, {1'b1, 5'h1f});
    rp = refc;
    for (i = 0; i < 40 && !(refc && !rp); i++) begin
      rp = refc;
      @(negedge aclk);
    end
    bus(1'b1, 4'h0, 32'h03f, 32'h0, 2'b00);
    chk(oe, 5'h00);
    n = 0;
    rp = refc;
    for (i = 0; i < 200 && load !== 1'b1; i++) begin
      @(negedge aclk);
      if (refc && !rp) n++;
      rp = refc;
    end
    if (load !== 1'b1) tmo();
    chk(n, 5);
    repeat (40) @(posedge aclk);
    chk({hold, oe}, {1'b1, 5'h00});
    bus(1'b0, 4'hc, 32'h6, 32'h6, 2'b00);
    bus(1'b1, 4'h0, 32'h077, 32'h0, 2'b00);
    @(negedge aclk);
    chk({hold, oe, byp}, {1'b0, 5'h1f, 1'b1});
    bus(1'b1, 4'h0, 32'h0, 32'h0, 2'b00);
    test_hold <= 1'b0;
    chk(byp, 1'b0);
    stop_test();
  end
endmodule // cbk_ctrl_tb_top
`default_nettype wire
